/* design/swow_params.svh */
// constants for the software and oscillator watchdog: offsets, fields, timing
// assumes a 32-bit AXI4-Lite register bus and a 250 MHz aclk
// Summary of operation
// - 8-bit control register with four low flags
// - oscillator reset sets its flag, software writable
// - overflow reset sets timer flag, software writable
// - arm then immediate start reloads counter
// - start bit runs timer, cannot stop
// - start presets upper seven counter bits
// - arm bit self-clears in third machine cycle
// - idle or power-down freezes the count
// - reset fires at counter state 7ffc
// - reset lasts 8 or 128 machine cycles
// - timer reset keeps timer running, sets flag
// - timer flag survives its own reset
// - reload register writable at any time
// - reference is rc clock divided by ten
// - failure selects rc clock and holds reset
// - oscillator reset keeps timer flag, stops timer
// - recovery holds reset for stabilise delay
// - external reset extends the released reset
// - external reset clears both flags
// - oscillator monitor cannot be disabled
// - power-down wake waits for oscillator plus delay
// - 15-bit counter at osc/12 or osc/192
// - reload low seven bits, bit7 prescale select
// - reload cleared by every reset kind
`ifndef SWOW_PARAMS_SVH
`define SWOW_PARAMS_SVH
`define SWOW_OFS_CTRL      32'h0000_00c0
`define SWOW_OFS_RELOAD    32'h0000_00c4
`define SWOW_OFS_STATUS    32'h0000_00c8
`define SWOW_BIT_OSC_FLAG  3
`define SWOW_BIT_TMR_FLAG  2
`define SWOW_BIT_ARM       1
`define SWOW_BIT_START     0
`define SWOW_CTRL_RESET    8'h00
`define SWOW_RELOAD_RESET  8'h00
`define SWOW_TRIP_STATE    15'h7ffc
`define SWOW_DIV_FAST      8'd12
`define SWOW_DIV_SLOW      8'd192
`define SWOW_MC_OSC        8'd12
`define SWOW_ARM_MC        2'd3
`define SWOW_RST_MC_FAST   8'd8
`define SWOW_RST_MC_SLOW   8'd128
`define SWOW_RC_DIV        4'd10
`define SWOW_WIN_LEN       8'd160
`define SWOW_STAB_US       1000
`define SWOW_CLK_MHZ       250
`define SWOW_STAB_CYC      (`SWOW_STAB_US * `SWOW_CLK_MHZ)
`endif

/* design/swow_pkg.sv */
// types shared by the watchdog design
// assumes the constants header is included by the design file
package swow_pkg;
  // oscillator supervisor states, one-hot
  typedef enum logic [2:0] {
    SWOW_OK   = 3'b001,
    SWOW_FAIL = 3'b010,
    SWOW_STAB = 3'b100
  } swow_osc_t;

  // complete module state
  typedef struct packed {
    logic        awok;      // write address held
    logic        awready;   // write address slot free, registered
    logic [31:0] awaddr;
    logic        wok;       // write data held
    logic        wready;    // write data slot free, registered
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bvalid;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic [1:0]  bresp;
    logic        osc_fail_reset_flag;
    logic        timer_reset_flag;
    logic        arm;
    logic [1:0]  arm_mc;    // machine cycles since arm set
    logic        run;
    logic [7:0]  reload;
    logic [6:0]  upper;
    logic [7:0]  lower;
    logic [7:0]  pre;       // prescaler count of osc cycles
    logic [3:0]  mc_div;    // osc to machine cycle divider
    logic        wdt_rst;
    logic [7:0]  wdt_rst_cnt;
    swow_osc_t   osc;
    logic [3:0]  rc_div;
    logic [7:0]  win;       // unused; rc_div counts the reference window
    logic [7:0]  main_cnt;  // main edges seen in window
    logic        main_q;
    logic        rc_q;
    logic [31:0] stab;
    logic        clk_sel_rc;
    logic        sys_rst;
  } swow_state_t;
endpackage

/* design/swow_top.sv */
// software watchdog timer and oscillator watchdog with an AXI4-Lite slave
// assumes the oscillator samples arrive synchronous to aclk, slower than it
//
// Local design decision: register access over AXI4-Lite.
`timescale 1ns/1ps
`include "swow_params.svh"
module swow_top import swow_pkg::*; #(
  parameter int unsigned STAB_CYC = `SWOW_STAB_CYC  // stabilise delay in aclk cycles
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,       // external reset, active low
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_awaddr,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  output logic [1:0]       s_axi_bresp,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  input  wire logic [31:0] s_axi_araddr,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  input  wire logic        main_osc,      // main oscillator sample
  input  wire logic        rc_osc,        // auxiliary rc oscillator sample
  input  wire logic        idle_mode,     // cpu idle
  input  wire logic        power_down,    // power-down, both oscillators stopped
  output logic             clk_sel_rc,    // internal clock from rc oscillator
  output logic             sys_reset      // internal reset request
);

  // ==========================================================================
  // state registers
  swow_state_t s_r;    // registered state
  swow_state_t s_nxt;  // next state

  // machine cycles for the timer reset pulse
  function automatic logic [7:0] rst_len(input logic psel);
    rst_len = psel ? `SWOW_RST_MC_SLOW : `SWOW_RST_MC_FAST;
  endfunction

  // word-aligned register select
  function automatic logic [1:0] sel(input logic [31:0] a);
    if (a[31:2] == `SWOW_OFS_CTRL >> 2) sel = 2'd1;
    else if (a[31:2] == `SWOW_OFS_RELOAD >> 2) sel = 2'd2;
    else if (a[31:2] == `SWOW_OFS_STATUS >> 2) sel = 2'd3;
    else sel = 2'd0;
  endfunction

  logic do_wr;   // write accepted this cycle
  logic wr_ctl;  // control byte written
  logic mc_tick; // one machine cycle elapsed
  logic osc_rst; // oscillator watchdog reset active
  logic [7:0] wb;

  // ==========================================================================
  // next state
  always_comb begin
    s_nxt   = s_r;
    wb      = s_r.wdata[7:0];
    do_wr   = s_r.awok && s_r.wok && !s_r.bvalid;
    wr_ctl  = do_wr && s_r.wstrb[0] && (sel(s_r.awaddr) == 2'd1);
    mc_tick = (s_r.mc_div == 4'(`SWOW_MC_OSC - 8'd1)) && !idle_mode && !power_down;
    osc_rst = s_r.osc != SWOW_OK;

    // bus: take address and data in either order
    if (s_axi_awvalid && s_r.awready) begin
      s_nxt.awok   = 1'b1;
      s_nxt.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_r.wready) begin
      s_nxt.wok   = 1'b1;
      s_nxt.wdata = s_axi_wdata;
      s_nxt.wstrb = s_axi_wstrb;
    end
    if (do_wr) begin
      s_nxt.bvalid = 1'b1;
      s_nxt.bresp  = (sel(s_r.awaddr) == 2'd0) ? 2'b10 : 2'b00;  // slverr unmapped
    end
    if (s_r.bvalid && s_axi_bready) begin
      s_nxt.bvalid = 1'b0;
      s_nxt.awok   = 1'b0;
      s_nxt.wok    = 1'b0;
    end
    // reads: one outstanding
    s_nxt.arready = 1'b0;
    if (s_axi_arvalid && !s_r.rvalid && !s_r.arready) begin
      s_nxt.arready = 1'b1;
      s_nxt.rvalid  = 1'b1;
      s_nxt.rresp   = 2'b00;
      case (sel(s_axi_araddr))
        2'd1: s_nxt.rdata = {28'h0, s_r.osc_fail_reset_flag, s_r.timer_reset_flag,
                             s_r.arm, s_r.run};
        2'd2: s_nxt.rdata = {24'h0, s_r.reload};
        2'd3: s_nxt.rdata = {29'h0, s_r.clk_sel_rc, s_r.wdt_rst, osc_rst};
        default: begin
          s_nxt.rdata = 32'h0;
          s_nxt.rresp = 2'b10;
        end
      endcase
    end
    if (s_r.rvalid && s_axi_rready) s_nxt.rvalid = 1'b0;

    // machine cycle divider, halted with the cpu clock
    if (!idle_mode && !power_down) begin
      s_nxt.mc_div = mc_tick ? 4'h0 : s_r.mc_div + 4'h1;
    end

    // reload register, writable at any time
    if (do_wr && s_r.wstrb[0] && sel(s_r.awaddr) == 2'd2) s_nxt.reload = wb;

    // control byte writes of the flags
    if (wr_ctl) begin
      s_nxt.osc_fail_reset_flag = wb[`SWOW_BIT_OSC_FLAG];
      s_nxt.timer_reset_flag    = wb[`SWOW_BIT_TMR_FLAG];
      if (wb[`SWOW_BIT_ARM]) begin
        s_nxt.arm    = 1'b1;
        s_nxt.arm_mc = 2'd0;
      end
    end

    // arm bit expires in its third machine cycle
    if (s_r.arm && mc_tick && !(wr_ctl && wb[`SWOW_BIT_ARM])) begin
      if (s_r.arm_mc == `SWOW_ARM_MC - 2'd1) s_nxt.arm = 1'b0;
      else s_nxt.arm_mc = s_r.arm_mc + 2'd1;
    end

    // start and refresh
    if (wr_ctl && wb[`SWOW_BIT_START]) begin
      if (!s_r.run || s_r.arm) begin
        s_nxt.upper = s_r.reload[6:0];
        s_nxt.lower = 8'h00;
        s_nxt.pre   = 8'h00;
        s_nxt.arm   = 1'b0;
      end
      s_nxt.run = 1'b1;
    end else if (s_r.run && !idle_mode && !power_down && !s_r.wdt_rst) begin
      // prescaled count at osc/12 or osc/192
      if (s_r.pre == (s_r.reload[7] ? `SWOW_DIV_SLOW : `SWOW_DIV_FAST) - 8'd1) begin
        s_nxt.pre = 8'h00;
        {s_nxt.upper, s_nxt.lower} = {s_r.upper, s_r.lower} + 15'h1;
        if ({s_r.upper, s_r.lower} + 15'h1 == `SWOW_TRIP_STATE) begin
          s_nxt.wdt_rst     = 1'b1;
          s_nxt.wdt_rst_cnt = rst_len(s_r.reload[7]);
          s_nxt.timer_reset_flag = 1'b1;
          // restart the divider so the pulse spans whole machine cycles
          s_nxt.mc_div      = 4'h0;
          s_nxt.reload      = 8'h00;
        end
      end else begin
        s_nxt.pre = s_r.pre + 8'h1;
      end
    end

    // timer reset pulse, timer stays enabled and restarts from zero reload
    if (s_r.wdt_rst && mc_tick) begin
      if (s_r.wdt_rst_cnt == 8'd1) begin
        s_nxt.wdt_rst = 1'b0;
        s_nxt.upper   = 7'h00;
        s_nxt.lower   = 8'h00;
      end
      s_nxt.wdt_rst_cnt = s_r.wdt_rst_cnt - 8'd1;
    end

    // oscillator monitor: count main edges in a window of ten rc periods
    s_nxt.main_q = main_osc;
    s_nxt.rc_q   = rc_osc;
    if (main_osc && !s_r.main_q && s_r.main_cnt != 8'hff) s_nxt.main_cnt = s_r.main_cnt + 8'h1;
    if (rc_osc && !s_r.rc_q) begin
      s_nxt.rc_div = (s_r.rc_div == `SWOW_RC_DIV - 4'd1) ? 4'h0 : s_r.rc_div + 4'h1;
    end
    if (rc_osc && !s_r.rc_q && s_r.rc_div == `SWOW_RC_DIV - 4'd1) begin
      s_nxt.main_cnt = 8'h00;
      // fewer than one main edge per divided reference period is a failure
      case (s_r.osc)
        SWOW_OK: if (s_r.main_cnt == 8'h00) s_nxt.osc = SWOW_FAIL;
        SWOW_FAIL: if (s_r.main_cnt != 8'h00) begin
          s_nxt.osc  = SWOW_STAB;
          s_nxt.stab = 32'h0;
        end
        SWOW_STAB: if (s_r.main_cnt == 8'h00) s_nxt.osc = SWOW_FAIL;
        default: s_nxt.osc = SWOW_FAIL;
      endcase
    end
    // power-down stops both oscillators, wake goes through the same check
    if (power_down) s_nxt.osc = SWOW_FAIL;
    if (s_r.osc == SWOW_STAB && s_nxt.osc == SWOW_STAB) begin
      if (s_r.stab == STAB_CYC - 1) s_nxt.osc = SWOW_OK;
      else s_nxt.stab = s_r.stab + 32'h1;
    end
    if (osc_rst && !power_down) begin
      s_nxt.osc_fail_reset_flag = 1'b1;
      s_nxt.run    = 1'b0;
      s_nxt.arm    = 1'b0;
      s_nxt.reload = 8'h00;
      s_nxt.wdt_rst = 1'b0;
    end
    s_nxt.awready    = !s_nxt.awok;
    s_nxt.wready     = !s_nxt.wok;
    s_nxt.clk_sel_rc = s_nxt.osc != SWOW_OK;
    s_nxt.sys_rst    = (s_nxt.osc != SWOW_OK && !power_down) || s_nxt.wdt_rst;
  end

  // ==========================================================================
  // registers; external reset clears both flags and the reload value
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_r         <= '0;
      s_r.osc     <= SWOW_FAIL;
      s_r.reload  <= `SWOW_RELOAD_RESET;
      s_r.sys_rst <= 1'b1;
      s_r.clk_sel_rc <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign s_axi_awready = s_r.awready;
  assign s_axi_wready  = s_r.wready;
  assign s_axi_bvalid  = s_r.bvalid;
  assign s_axi_bresp   = s_r.bresp;
  assign s_axi_arready = s_r.arready;
  assign s_axi_rvalid  = s_r.rvalid;
  assign s_axi_rdata   = s_r.rdata;
  assign s_axi_rresp   = s_r.rresp;
  assign clk_sel_rc    = s_r.clk_sel_rc;
  assign sys_reset     = s_r.sys_rst;

  // ==========================================================================
  // assertions
  // all checks but a_reload_write watch registered state, so a failure points at the edge that
  // launched the bad value; the bus side is left to the handshake checks below

  // external reset clears both status flags
  property p_flags_cleared;
    @(posedge aclk) !aresetn |=> (!s_r.osc_fail_reset_flag && !s_r.timer_reset_flag);
  endproperty
  a_flags_cleared: assert property (p_flags_cleared) else $error("flags kept");

  // a timer reset sets its flag and leaves the timer running
  property p_trip_sets_flag;
    @(posedge aclk) disable iff (!aresetn)
      $rose(s_r.wdt_rst) |-> s_r.timer_reset_flag && s_r.run;
  endproperty
  a_trip_sets_flag: assert property (p_trip_sets_flag) else $error("trip flag");

  // an oscillator reset sets its flag and stops the timer
  property p_osc_flag;
    @(posedge aclk) disable iff (!aresetn)
      (osc_rst && !power_down) |=> s_r.osc_fail_reset_flag && !s_r.run;
  endproperty
  a_osc_flag: assert property (p_osc_flag) else $error("osc reset effects");

  // a failed oscillator keeps the rc clock and the reset
  property p_fail_reset;
    @(posedge aclk) disable iff (!aresetn)
      (s_r.osc == SWOW_FAIL && !power_down) |=> s_r.sys_rst && s_r.clk_sel_rc;
  endproperty
  a_fail_reset: assert property (p_fail_reset) else $error("fail not held");

  // software has no way to stop a running timer
  property p_no_stop;
    @(posedge aclk) disable iff (!aresetn) (s_r.run && !osc_rst) |=> s_r.run;
  endproperty
  a_no_stop: assert property (p_no_stop) else $error("timer stopped");

  // idle freezes the count unless a start or refresh lands
  property p_hold_idle;
    @(posedge aclk) disable iff (!aresetn)
      (idle_mode && !wr_ctl && !osc_rst) |=> $stable({s_r.upper, s_r.lower});
  endproperty
  a_hold_idle: assert property (p_hold_idle) else $error("count moved in idle");

  // the arm bit never outlives its third machine cycle
  property p_arm_limit;
    @(posedge aclk) disable iff (!aresetn) s_r.arm |-> s_r.arm_mc < `SWOW_ARM_MC;
  endproperty
  a_arm_limit: assert property (p_arm_limit) else $error("arm bit too long");

  // the timer reset pulse is driven out on the same edge
  property p_rst_out;
    @(posedge aclk) disable iff (!aresetn) s_r.wdt_rst |-> s_r.sys_rst;
  endproperty
  a_rst_out: assert property (p_rst_out) else $error("timer reset not out");

  // one prescaled step short of the trip state, nothing else pending
  sequence s_at_trip;
    s_r.run && !s_r.wdt_rst && !idle_mode && !power_down && !osc_rst && !wr_ctl &&
    ({s_r.upper, s_r.lower} == `SWOW_TRIP_STATE - 15'h1) &&
    (s_r.pre == (s_r.reload[7] ? `SWOW_DIV_SLOW : `SWOW_DIV_FAST) - 8'd1);
  endsequence

  // reaching the trip state fires the timer reset at once
  property p_trip_state;
    @(posedge aclk) disable iff (!aresetn)
      s_at_trip |=> s_r.wdt_rst && s_r.sys_rst && s_r.timer_reset_flag;
  endproperty
  a_trip_state: assert property (p_trip_state) else $error("no trip");

  // pulse length follows the prescale select in force at the trip
  property p_pulse_len;
    @(posedge aclk) disable iff (!aresetn)
      $rose(s_r.wdt_rst) |-> s_r.wdt_rst_cnt == rst_len($past(s_r.reload[7]));
  endproperty
  a_pulse_len: assert property (p_pulse_len) else $error("pulse length");

  // a timer reset clears the reload value
  property p_reload_cleared;
    @(posedge aclk) disable iff (!aresetn) $rose(s_r.wdt_rst) |-> s_r.reload == 8'h00;
  endproperty
  a_reload_cleared: assert property (p_reload_cleared) else $error("reload kept");

  // a reload write lands whether or not the timer runs
  property p_reload_write;
    @(posedge aclk) disable iff (!aresetn)
      (do_wr && s_r.wstrb[0] && sel(s_r.awaddr) == 2'd2 && !osc_rst &&
       !(s_nxt.wdt_rst && !s_r.wdt_rst)) |=> s_r.reload == $past(wb);
  endproperty
  a_reload_write: assert property (p_reload_write) else $error("reload lost");

  // a first start presets the upper part and clears the lower part
  property p_preset;
    @(posedge aclk) disable iff (!aresetn)
      (wr_ctl && wb[`SWOW_BIT_START] && !s_r.run) |=>
      (s_r.upper == $past(s_r.reload[6:0])) && (s_r.lower == 8'h00);
  endproperty
  a_preset: assert property (p_preset) else $error("start preset");

  // an armed start while running reloads and consumes the arm bit
  property p_refresh;
    @(posedge aclk) disable iff (!aresetn)
      (wr_ctl && wb[`SWOW_BIT_START] && s_r.run && s_r.arm && !s_r.wdt_rst) |=>
      (s_r.upper == $past(s_r.reload[6:0])) && (s_r.lower == 8'h00) && !s_r.arm;
  endproperty
  a_refresh: assert property (p_refresh) else $error("refresh lost");

  // failure then recovery: reset and rc clock held as stabilising begins
  sequence s_osc_failed;
    s_r.osc == SWOW_FAIL;
  endsequence
  sequence s_stab_start;
    s_osc_failed ##1 (s_r.osc == SWOW_STAB);
  endsequence
  property p_recover_held;
    @(posedge aclk) disable iff (!aresetn) s_stab_start |-> s_r.sys_rst && s_r.clk_sel_rc;
  endproperty
  a_recover_held: assert property (p_recover_held) else $error("recovery unheld");

  // stabilising holds the reset and the rc clock throughout
  property p_stab_out;
    @(posedge aclk) disable iff (!aresetn)
      (s_r.osc == SWOW_STAB) |-> s_r.sys_rst && s_r.clk_sel_rc;
  endproperty
  a_stab_out: assert property (p_stab_out) else $error("stabilise unheld");

  // a failed oscillator never goes straight back to running
  property p_no_skip;
    @(posedge aclk) disable iff (!aresetn) s_osc_failed |=> s_r.osc != SWOW_OK;
  endproperty
  a_no_skip: assert property (p_no_skip) else $error("stabilise skipped");

  // a healthy oscillator drives the internal clock
  property p_ok_out;
    @(posedge aclk) disable iff (!aresetn) (s_r.osc == SWOW_OK) |-> !s_r.clk_sel_rc;
  endproperty
  a_ok_out: assert property (p_ok_out) else $error("rc clock kept");

  // power-down stops both oscillators, so the check restarts from failure
  property p_pd_fail;
    @(posedge aclk) disable iff (!aresetn)
      power_down |=> (s_r.osc == SWOW_FAIL) && s_r.clk_sel_rc;
  endproperty
  a_pd_fail: assert property (p_pd_fail) else $error("power-down not failed");

  // write response stands until taken
  property p_bvalid_hold;
    @(posedge aclk) disable iff (!aresetn) (s_r.bvalid && !s_axi_bready) |=> s_r.bvalid;
  endproperty
  a_bvalid_hold: assert property (p_bvalid_hold) else $error("bvalid dropped");

  // read data stands until taken
  property p_rvalid_hold;
    @(posedge aclk) disable iff (!aresetn)
      (s_r.rvalid && !s_axi_rready) |=> s_r.rvalid && $stable(s_r.rdata);
  endproperty
  a_rvalid_hold: assert property (p_rvalid_hold) else $error("rvalid dropped");

endmodule // swow_top

/* testbench/software_and_oscillator_watchdog_tb.sv */
// self-checking bench for the software and oscillator watchdog
// assumes swow_top with an axi4-lite slave and aclk at 250 mhz
`timescale 1ns/1ps
`include "swow_params.svh"
module software_and_oscillator_watchdog_tb import swow_pkg::*; ;
  // ==========================================================
  // compare helper
  `define CHK(got, exp) begin total_checks++; if ((got) !== (exp)) begin err_count++; \
    $display("[FAIL] %0t got %0h exp %0h", $time, got, exp); end end
  logic        aclk = 1'b0;     // system clock
  logic        aresetn = 1'b0;  // external reset
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0;
  logic [3:0]  s_axi_wstrb = 4'h0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic        main_osc = 1'b0, rc_osc = 1'b0;  // oscillator samples
  logic        idle_mode = 1'b0, power_down = 1'b0;
  logic        clk_sel_rc, sys_reset;
  logic        main_run = 1'b1;                 // low models a dead crystal
  logic [2:0]  ph = 3'h0;                       // oscillator phase
  logic [31:0] d;                               // last read data
  logic [1:0]  r;                               // last response
  int          n;                               // cycle count of last wait
  int          err_count = 0;
  int          total_checks = 0;
  always #2 aclk = ~aclk;
  // main runs at twice the rc rate, far above the divided reference
  always @(posedge aclk) begin
    ph <= ph + 3'h1;
    rc_osc <= ph[2];
    if (main_run) begin
      main_osc <= ph[1];
    end
  end
  swow_top #(.STAB_CYC(20)) dut (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_araddr(s_axi_araddr),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .main_osc(main_osc), .rc_osc(rc_osc),
    .idle_mode(idle_mode), .power_down(power_down),
    .clk_sel_rc(clk_sel_rc), .sys_reset(sys_reset));
  // ==========================================================
  // bus tasks: address and data offered together, each dropped when taken
  task automatic axw(input logic [31:0] a, input logic [31:0] v);
    bit ah, dh;
    ah = 0;
    dh = 0;
    @(posedge aclk);
    s_axi_awvalid <= 1'b1; s_axi_awaddr <= a; s_axi_wvalid <= 1'b1;
    s_axi_wdata <= v; s_axi_wstrb <= 4'hf; s_axi_bready <= 1'b1;
    while (!(ah && dh)) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) begin ah = 1; s_axi_awvalid <= 1'b0; end
      if (s_axi_wvalid && s_axi_wready) begin dh = 1; s_axi_wvalid <= 1'b0; end
    end
    while (s_axi_bvalid !== 1'b1) @(posedge aclk);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic axr(input logic [31:0] a);
    @(posedge aclk);
    s_axi_arvalid <= 1'b1; s_axi_araddr <= a; s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  // waits for sys_reset to reach a level, bounded
  task automatic wait_lvl(input logic v, input int lim);
    n = 0;
    while (sys_reset !== v && n < lim) begin @(posedge aclk); n++; end
    if (n >= lim) begin err_count++; $display("[FAIL] %0t reset level wait", $time); end
  endtask
  // ==========================================================
  // scenarios
  task automatic t_regs();
    axr(`SWOW_OFS_CTRL);
    `CHK(d[7:4], 4'h0)
    `CHK(d[2:0], 3'h0)
    axr(`SWOW_OFS_RELOAD);
    `CHK(d[7:0], 8'h00)
    axr(32'h0000_0040);
    `CHK(r, 2'h2)
    axw(32'h0000_0044, 32'h0000_00ff);
    `CHK(r, 2'h2)
    axw(`SWOW_OFS_CTRL, 32'h0000_000c);
    axr(`SWOW_OFS_CTRL);
    `CHK(d[3:2], 2'b11)
    axw(`SWOW_OFS_CTRL, 32'h0000_0000);
    axr(`SWOW_OFS_CTRL);
    `CHK(d[3:2], 2'b00)
  endtask
  task automatic t_arm();
    axw(`SWOW_OFS_CTRL, 32'h0000_0002);
    axr(`SWOW_OFS_CTRL);
    `CHK(d[1], 1'b1)
    repeat (48) @(posedge aclk);
    axr(`SWOW_OFS_CTRL);
    `CHK(d[1:0], 2'b00)
  endtask
  // reload 0x7f leaves 0xfc machine cycles to the trip state
  task automatic t_timeout();
    axw(`SWOW_OFS_CTRL, 32'h0000_0001);
    axw(`SWOW_OFS_CTRL, 32'h0000_0000);
    axr(`SWOW_OFS_CTRL);
    `CHK(d[0], 1'b1)
    axw(`SWOW_OFS_RELOAD, 32'h0000_007f);
    axr(`SWOW_OFS_RELOAD);
    `CHK(d[7:0], 8'h7f)
    axw(`SWOW_OFS_CTRL, 32'h0000_0002);
    axw(`SWOW_OFS_CTRL, 32'h0000_0001);
    idle_mode <= 1'b1;
    repeat (1000) @(posedge aclk);
    idle_mode <= 1'b0;
    `CHK(sys_reset, 1'b0)
    wait_lvl(1'b1, 5000);
    `CHK((n >= 2990 && n <= 3040), 1'b1)
    wait_lvl(1'b0, 300);
    `CHK((n >= 95 && n <= 97), 1'b1)
    axr(`SWOW_OFS_CTRL);
    `CHK(d[2], 1'b1)
    `CHK(d[0], 1'b1)
    axr(`SWOW_OFS_RELOAD);
    `CHK(d[7:0], 8'h00)
  endtask
  task automatic t_osc();
    main_run <= 1'b0;
    wait_lvl(1'b1, 1000);
    `CHK(clk_sel_rc, 1'b1)
    repeat (300) @(posedge aclk);
    `CHK(sys_reset, 1'b1)
    axr(`SWOW_OFS_STATUS);
    `CHK(d[2:0], 3'b101)
    main_run <= 1'b1;
    wait_lvl(1'b0, 2000);
    `CHK((n >= 20), 1'b1)
    `CHK(clk_sel_rc, 1'b0)
    axr(`SWOW_OFS_CTRL);
    `CHK(d[3], 1'b1)
    `CHK(d[2], 1'b1)
    `CHK(d[0], 1'b0)
  endtask
  // power-down stops both oscillators; wake goes through the full check
  task automatic t_pd();
    power_down <= 1'b1;
    repeat (40) @(posedge aclk);
    `CHK(clk_sel_rc, 1'b1)
    power_down <= 1'b0;
    wait_lvl(1'b1, 300);
    wait_lvl(1'b0, 2000);
    `CHK((n >= 20), 1'b1)
    `CHK(clk_sel_rc, 1'b0)
  endtask
  // external reset outlasting the oscillator recovery
  task automatic t_ext();
    main_run <= 1'b0;
    wait_lvl(1'b1, 1000);
    aresetn <= 1'b0;
    main_run <= 1'b1;
    repeat (400) @(posedge aclk);
    `CHK(sys_reset, 1'b1)
    aresetn <= 1'b1;
    wait_lvl(1'b0, 2000);
    axr(`SWOW_OFS_CTRL);
    `CHK(d[2], 1'b0)
  endtask
  // ==========================================================
  // verdict, reached from the main sequence or the watchdog
  task automatic report_and_stop();
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    wait_lvl(1'b0, 2000);
    t_regs();
    t_arm();
    t_timeout();
    t_osc();
    t_pd();
    t_ext();
    report_and_stop();
  end
  // whole run is about 6k cycles; this 100k-cycle limit is over fifteen times that
  initial begin
    #400000;
    err_count++;
    report_and_stop();
  end
endmodule // software_and_oscillator_watchdog_tb
